// ---- src/ihbfe_cfg.svh ----
`ifndef IHBFE_CFG_SVH
`define IHBFE_CFG_SVH
`define IHBFE_UA_W      7
`define IHBFE_LA_W      17
`define IHBFE_IO_BASE   16'h03b0
`define IHBFE_IO_LAST   16'h03df
`define IHBFE_MEM_BASE  7'h05
`define IHBFE_IDX_RST   8'h00
`define IHBFE_DAT_RST   8'h00
`endif

// ---- src/ihbfe_pkg.sv ----
package ihbfe_pkg;
    typedef enum logic [3:0] {
        XFER_IDLE = 4'b0001,
        XFER_WORD = 4'b0010,
        XFER_HIGH = 4'b0100,
        XFER_LOW  = 4'b1000
    } ihbfe_width_t;
    typedef struct packed {
        logic       ioRd;
        logic       ioWr;
        logic       memRd;
        logic       memWr;
    } ihbfe_strb_t;
endpackage

// ---- src/ihbfe_front_end.sv ----
`timescale 1ns/100ps
`include "ihbfe_cfg.svh"
// Behaviour
// - Upper seven address lines latched on latch-enable falling edge, used in memory decode.
// - Upper data lane used both ways for 16-bit and high-byte transfers.
// - Byte-high enable with address bit 0 decodes width and lane.
// - Address enable high blocks I/O cycles; memory cycles unaffected.
// - Local-bus mode drives EEPROM pins as active-low lane output enables.
// - I/O write loads selected register on rising edge of write strobe.
// - 16-bit I/O write: index from low byte, data from high byte.
module ihbfe_front_end #(
    parameter int UA_W = `IHBFE_UA_W
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 clkEn,
    input  wire logic [UA_W-1:0]      upperAddr,
    input  wire logic [16:0]          sysAddr,
    input  wire logic                 addrLatchEn,
    input  wire logic                 byteHighEn_n,
    input  wire logic                 addrEnable,
    input  wire ihbfe_pkg::ihbfe_strb_t strb_n,
    input  wire logic                 localBusMode,
    input  wire logic [15:0]          dataIn,
    output logic [15:0]               dataOut,
    output logic                      lowLaneOe,
    output logic                      highLaneOe,
    output logic                      eeprom_select_pin,
    output logic                      eeprom_data_in_pin,
    input  wire logic                 eepromSelectCore,
    input  wire logic                 eepromDataInCore,
    output logic                      memHit,
    output logic [7:0]                indexOut,
    output logic [7:0]                dataRegOut,
    output logic                      regWrite
);
    // Input synchronisers
    logic [1:0] aleSync_reg, iorSync_reg, iowSync_reg, mrdSync_reg, mwrSync_reg;
    logic [1:0] aleSync_next, iorSync_next, iowSync_next, mrdSync_next, mwrSync_next;
    logic [UA_W-1:0] upA1_reg, upA2_reg, upLatch_reg, upLatch_next;
    logic [UA_W-1:0] upShadow_reg, upShadow_next;
    logic [15:0] wrData_reg, wrData_next;
    logic        wrOdd_reg, wrOdd_next;
    ihbfe_pkg::ihbfe_width_t wrWidth_reg, wrWidth_next;
    logic [16:0] saA1_reg, saA2_reg;
    logic [15:0] dA1_reg, dA2_reg;
    logic [1:0]  ctlA1_reg, ctlA2_reg;
    logic        aleOld_reg, iowOld_reg, aleOld_next, iowOld_next;
    logic [7:0]  idx_reg, idx_next, dat_reg, dat_next;
    logic        wr_reg, wr_next;
    logic [15:0] dOut_reg, dOut_next;
    ihbfe_pkg::ihbfe_width_t width;
    logic ioSel, ioRdAct, memRdAct, memWrAct, ioWrAct, rdAct;

    // Width and lane decode
    function automatic ihbfe_pkg::ihbfe_width_t decodeWidth(input logic bhe_n, input logic a0);
        if (!bhe_n && !a0) begin
            decodeWidth = ihbfe_pkg::XFER_WORD;
        end else if (!bhe_n) begin
            decodeWidth = ihbfe_pkg::XFER_HIGH;
        end else begin
            decodeWidth = ihbfe_pkg::XFER_LOW;
        end
    endfunction

    always_comb begin
        aleSync_next = {aleSync_reg[0], addrLatchEn};
        iorSync_next = {iorSync_reg[0], ~strb_n.ioRd};
        iowSync_next = {iowSync_reg[0], ~strb_n.ioWr};
        mrdSync_next = {mrdSync_reg[0], ~strb_n.memRd};
        mwrSync_next = {mwrSync_reg[0], ~strb_n.memWr};
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aleSync_reg <= 2'h0;
            iorSync_reg <= 2'h0;
            iowSync_reg <= 2'h0;
            mrdSync_reg <= 2'h0;
            mwrSync_reg <= 2'h0;
            upA1_reg <= '0;
            upA2_reg <= '0;
            saA1_reg <= 17'h00000;
            saA2_reg <= 17'h00000;
            dA1_reg <= 16'h0000;
            dA2_reg <= 16'h0000;
            ctlA1_reg <= 2'h3;
            ctlA2_reg <= 2'h3;
        end else if (clkEn) begin
            aleSync_reg <= aleSync_next;
            iorSync_reg <= iorSync_next;
            iowSync_reg <= iowSync_next;
            mrdSync_reg <= mrdSync_next;
            mwrSync_reg <= mwrSync_next;
            upA1_reg <= upperAddr;
            upA2_reg <= upA1_reg;
            saA1_reg <= sysAddr;
            saA2_reg <= saA1_reg;
            dA1_reg <= dataIn;
            dA2_reg <= dA1_reg;
            ctlA1_reg <= {byteHighEn_n, addrEnable};
            ctlA2_reg <= ctlA1_reg;
        end
    end

    // Cycle qualification
    always_comb begin
        width    = decodeWidth(ctlA2_reg[1], saA2_reg[0]);
        ioSel    = ({1'b0, saA2_reg[15:0]} >= {1'b0, `IHBFE_IO_BASE})
                   && (saA2_reg[15:0] <= `IHBFE_IO_LAST) && !ctlA2_reg[0];
        memHit   = (upLatch_reg == `IHBFE_MEM_BASE);
        ioRdAct  = iorSync_reg[1] && ioSel;
        ioWrAct  = iowSync_reg[1] && ioSel;
        memRdAct = mrdSync_reg[1] && memHit;
        memWrAct = mwrSync_reg[1] && memHit;
        rdAct    = ioRdAct || memRdAct;
    end

    // Address latch, write capture, read data
    always_comb begin
        aleOld_next   = aleSync_reg[1];
        iowOld_next   = ioWrAct;
        upShadow_next = upShadow_reg;
        upLatch_next  = upLatch_reg;
        wrData_next   = wrData_reg;
        wrWidth_next  = wrWidth_reg;
        wrOdd_next    = wrOdd_reg;
        idx_next      = idx_reg;
        dat_next      = dat_reg;
        wr_next       = 1'b0;
        dOut_next     = {dat_reg, idx_reg};
        // Track upper lines while latch enable stands; later pin moves are harmless
        if (aleSync_reg[1]) begin
            upShadow_next = upA2_reg;
        end
        if (aleOld_reg && !aleSync_reg[1]) begin
            upLatch_next = upShadow_reg;
        end
        // Keep lanes and decode from the last active strobe sample
        if (ioWrAct) begin
            wrData_next  = dA2_reg;
            wrWidth_next = width;
            wrOdd_next   = saA2_reg[0];
        end
        if (iowOld_reg && !iowSync_reg[1]) begin
            wr_next = 1'b1;
            if (wrWidth_reg == ihbfe_pkg::XFER_WORD) begin
                idx_next = wrData_reg[7:0];
                dat_next = wrData_reg[15:8];
            end else if (wrWidth_reg == ihbfe_pkg::XFER_HIGH) begin
                dat_next = wrData_reg[15:8];
            end else if (wrOdd_reg) begin
                dat_next = wrData_reg[7:0];
            end else begin
                idx_next = wrData_reg[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aleOld_reg  <= 1'b0;
            iowOld_reg  <= 1'b0;
            upLatch_reg <= '0;
            upShadow_reg <= '0;
            wrData_reg  <= 16'h0000;
            wrWidth_reg <= ihbfe_pkg::XFER_IDLE;
            wrOdd_reg   <= 1'b0;
            idx_reg     <= `IHBFE_IDX_RST;
            dat_reg     <= `IHBFE_DAT_RST;
            wr_reg      <= 1'b0;
            dOut_reg    <= 16'h0000;
        end else if (clkEn) begin
            aleOld_reg  <= aleOld_next;
            iowOld_reg  <= iowOld_next;
            upLatch_reg <= upLatch_next;
            upShadow_reg <= upShadow_next;
            wrData_reg  <= wrData_next;
            wrWidth_reg <= wrWidth_next;
            wrOdd_reg   <= wrOdd_next;
            idx_reg     <= idx_next;
            dat_reg     <= dat_next;
            wr_reg      <= wr_next;
            dOut_reg    <= dOut_next;
        end
    end

    // Lane drive and pin muxing
    always_comb begin
        dataOut    = dOut_reg;
        lowLaneOe  = rdAct && (width != ihbfe_pkg::XFER_HIGH);
        highLaneOe = rdAct && (width != ihbfe_pkg::XFER_LOW);
        if (rdAct && width == ihbfe_pkg::XFER_HIGH) begin
            dataOut = {dOut_reg[15:8], 8'h00};
        end
        eeprom_select_pin  = localBusMode ? ~lowLaneOe : eepromSelectCore;
        eeprom_data_in_pin = localBusMode ? ~highLaneOe : eepromDataInCore;
        indexOut   = idx_reg;
        dataRegOut = dat_reg;
        regWrite   = wr_reg;
    end

    // Checks
    a_upper_latch: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && $past(clkEn) && $fell(aleSync_reg[1]) |=> upLatch_reg == $past(upA2_reg, 2))
        else $error("upper address not latched");
    a_dma_block: assert property (@(posedge ref_clk) disable iff (rst)
        ctlA2_reg[0] && !mrdSync_reg[1] |-> !lowLaneOe && !highLaneOe)
        else $error("io answered during dma");
    a_high_lane: assert property (@(posedge ref_clk) disable iff (rst)
        highLaneOe |-> !ctlA2_reg[1] && (iorSync_reg[1] || mrdSync_reg[1]))
        else $error("high lane driven on low transfer");
    a_low_lane: assert property (@(posedge ref_clk) disable iff (rst)
        rdAct && ctlA2_reg[1] |-> lowLaneOe && !highLaneOe)
        else $error("low lane not driven");
    a_width_dec: assert property (@(posedge ref_clk) disable iff (rst)
        width == (ctlA2_reg[1] ? ihbfe_pkg::XFER_LOW
                               : (saA2_reg[0] ? ihbfe_pkg::XFER_HIGH : ihbfe_pkg::XFER_WORD)))
        else $error("width decode wrong");
    a_lane_pins: assert property (@(posedge ref_clk) disable iff (rst)
        localBusMode |-> eeprom_select_pin == !lowLaneOe && eeprom_data_in_pin == !highLaneOe)
        else $error("lane enable pins wrong");
    a_write_edge: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && $past(clkEn) && $fell(iowSync_reg[1]) && $past(ioSel) |=> regWrite)
        else $error("write strobe edge missed");
    a_word_write: assert property (@(posedge ref_clk) disable iff (rst)
        clkEn && $past(clkEn) && iowOld_reg && !iowSync_reg[1]
        && wrWidth_reg == ihbfe_pkg::XFER_WORD
        |=> indexOut == $past(dA2_reg[7:0], 2) && dataRegOut == $past(dA2_reg[15:8], 2))
        else $error("word write lanes wrong");
    a_freeze_hold: assert property (@(posedge ref_clk) disable iff (rst)
        !clkEn |=> $stable(indexOut) && $stable(dataRegOut) && $stable(upLatch_reg))
        else $error("state moved while frozen");
    c_word_wr: cover property (@(posedge ref_clk) disable iff (rst) regWrite && !ctlA2_reg[1]);
    c_io_read: cover property (@(posedge ref_clk) disable iff (rst) ioRdAct);
    c_mem_hit: cover property (@(posedge ref_clk) disable iff (rst) memRdAct);
    c_mem_wr: cover property (@(posedge ref_clk) disable iff (rst) memWrAct);
endmodule

// ---- testbench/ihbfe_host_model.sv ----
`timescale 1ns/100ps
module ihbfe_host_model (
    input  wire logic                   ref_clk,
    input  wire logic [19:0]            laneSeen,
    output logic [6:0]                  upperAddr,
    output logic [16:0]                 sysAddr,
    output logic                        addrLatchEn,
    output logic                        byteHighEn_n,
    output logic                        addrEnable,
    output ihbfe_pkg::ihbfe_strb_t      strb_n,
    output logic [15:0]                 dataIn
);
    // Idle bus from time zero
    initial begin
        {upperAddr, sysAddr, addrLatchEn, byteHighEn_n, addrEnable} = 27'h0000003;
        strb_n = 4'hf;
        dataIn = 16'hffff;
    end
    // Bus cycle with strobe pattern st; d drives both lanes, lanes sampled just before strobe release
    task automatic io_cycle(input logic [3:0] st, input logic [16:0] a, input logic bhe, aen,
                            input logic [15:0] d, output logic [19:0] seen);
        @(negedge ref_clk);
        {sysAddr, byteHighEn_n, addrEnable, dataIn} = {a, bhe, aen, d};
        @(negedge ref_clk);
        strb_n = st;
        repeat (6) @(negedge ref_clk);
        seen = laneSeen;
        strb_n = 4'hf;
        @(negedge ref_clk);
        {sysAddr, dataIn} = {~a, ~d};
        repeat (5) @(negedge ref_clk);
    endtask
    // Address latch pulse, upper lines moved after the fall
    task automatic latch_upper(input logic [6:0] u);
        @(negedge ref_clk);
        {upperAddr, addrLatchEn} = {u, 1'b1};
        repeat (4) @(negedge ref_clk);
        addrLatchEn = 1'b0;
        @(negedge ref_clk);
        upperAddr = ~u;
        repeat (7) @(negedge ref_clk);
    endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
    logic                   ref_clk = 1'b0;
    logic                   rst = 1'b1;
    logic                   localBusMode = 1'b1;
    logic                   clkEn = 1'b1;
    logic [6:0]             upperAddr;
    logic [16:0]            sysAddr;
    logic                   ale, bhe_n, aen, oeL, oeH, selPin, dinPin, memHit, regWrite;
    ihbfe_pkg::ihbfe_strb_t strb_n;
    logic [15:0]            dataIn, dataOut;
    logic [7:0]             indexOut, dataRegOut;
    logic [19:0]            seen, s;
    int                     fail_count = 0;
    int                     check_count = 0;
    int                     pulses = 0;
    // Clock, pulse counter, observed lanes
    always #12.5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) if (regWrite === 1'b1) pulses++;
    assign seen = {oeL, oeH, selPin, dinPin, dataOut};
    ihbfe_front_end dut_u (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .upperAddr(upperAddr),
        .sysAddr(sysAddr), .addrLatchEn(ale), .byteHighEn_n(bhe_n), .addrEnable(aen),
        .strb_n(strb_n), .localBusMode(localBusMode), .dataIn(dataIn), .dataOut(dataOut),
        .lowLaneOe(oeL), .highLaneOe(oeH), .eeprom_select_pin(selPin),
        .eeprom_data_in_pin(dinPin), .eepromSelectCore(1'b1), .eepromDataInCore(1'b0),
        .memHit(memHit), .indexOut(indexOut), .dataRegOut(dataRegOut), .regWrite(regWrite));
    ihbfe_host_model host_u (.ref_clk(ref_clk), .laneSeen(seen), .upperAddr(upperAddr),
        .sysAddr(sysAddr), .addrLatchEn(ale), .byteHighEn_n(bhe_n), .addrEnable(aen),
        .strb_n(strb_n), .dataIn(dataIn));
    task automatic check(input string name, input logic [19:0] exp, input logic [19:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Write, then judge pulse count and both registers
    task automatic wr(input logic [16:0] a, input logic b, e, input logic [15:0] d,
                      input logic [7:0] ei, ed, input int ep);
        int p;
        p = pulses;
        host_u.io_cycle(4'hb, a, b, e, d, s);
        check("pulses", 20'(ep), 20'(pulses - p));
        check("index", {12'h000, ei}, {12'h000, indexOut});
        check("data", {12'h000, ed}, {12'h000, dataRegOut});
    endtask
    task automatic rd(input logic [16:0] a, input logic b, e, input logic [3:0] el);
        host_u.io_cycle(4'h7, a, b, e, 16'h0000, s);
        check("lanes", {16'h0000, el}, {16'h0000, s[19:16]});
    endtask
    task automatic s_reset;
        repeat (2) @(negedge ref_clk);
        check("reset", 20'h00000, {memHit, regWrite, indexOut, dataRegOut, 2'b00});
        check("reset lanes", 20'h30000, seen);
    endtask
    task automatic s_writes;
        wr(17'h003c4, 1'b0, 1'b0, 16'h5a03, 8'h03, 8'h5a, 1);
        wr(17'h003ce, 1'b1, 1'b0, 16'hee07, 8'h07, 8'h5a, 1);
        wr(17'h003df, 1'b1, 1'b0, 16'hee9c, 8'h07, 8'h9c, 1);
        wr(17'h003c5, 1'b0, 1'b0, 16'h44ee, 8'h07, 8'h44, 1);
    endtask
    task automatic s_refused;
        wr(17'h003c4, 1'b0, 1'b1, 16'h1111, 8'h07, 8'h44, 0);
        wr(17'h003af, 1'b0, 1'b0, 16'h2222, 8'h07, 8'h44, 0);
        wr(17'h003e0, 1'b0, 1'b0, 16'h3333, 8'h07, 8'h44, 0);
    endtask
    // Frozen clock enable ignores a write, then a write lands again
    task automatic s_freeze;
        clkEn = 1'b0;
        wr(17'h003c4, 1'b0, 1'b0, 16'h6606, 8'h07, 8'h44, 0);
        clkEn = 1'b1;
        wr(17'h003c4, 1'b0, 1'b0, 16'h4407, 8'h07, 8'h44, 1);
    endtask
    task automatic s_reads;
        rd(17'h003c4, 1'b0, 1'b0, 4'hc);
        check("read data", 20'h04407, {4'h0, s[15:0]});
        rd(17'h003ce, 1'b1, 1'b0, 4'h9);
        rd(17'h003c5, 1'b0, 1'b0, 4'h6);
        check("high read", 20'h04400, {4'h0, s[15:0]});
        rd(17'h003c4, 1'b0, 1'b1, 4'h3);
        localBusMode = 1'b0;
        rd(17'h003c4, 1'b0, 1'b0, 4'he);
    endtask
    task automatic s_mem;
        int p;
        localBusMode = 1'b1;
        host_u.latch_upper(7'h05);
        check("mem hit", 20'h00001, {19'h00000, memHit});
        host_u.io_cycle(4'hd, 17'h00000, 1'b0, 1'b1, 16'h0000, s);
        check("mem read", 20'hc4407, s);
        p = pulses;
        host_u.io_cycle(4'he, 17'h00000, 1'b0, 1'b0, 16'h1234, s);
        check("mem write lanes", 20'h34407, s);
        check("mem write pulses", 20'h00000, 20'(pulses - p));
        host_u.latch_upper(7'h04);
        check("mem miss", 20'h00000, {19'h00000, memHit});
        host_u.io_cycle(4'hd, 17'h00000, 1'b0, 1'b1, 16'h0000, s);
        check("mem miss read", 20'h34407, s);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Reset, scenarios, verdict
    initial begin
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        s_reset();
        s_writes();
        s_refused();
        s_freeze();
        s_reads();
        s_mem();
        finish_test();
    end
    // Watchdog
    initial begin
        #(25 * 3000);
        fail_count++;
        finish_test();
    end
endmodule
